// file: jsfp_pkg.sv
// Constants, field layout and types for the joystick status frame packer.
// Assumes a single 200 MHz system clock and a classic Wishbone register bus.
package jsfp_pkg;
	// Timing
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned FRAME_PERIOD_MS = 20;
	localparam int unsigned FRAME_PERIOD_CYCLES = CLK_FREQ_HZ / 1000 * FRAME_PERIOD_MS;
	localparam int TIMER_W = 23;

	// Widths
	localparam int AXIS_IN_W = 11;
	localparam int POS_W = 10;
	localparam int BTN_N = 12;
	localparam int SA_W = 8;
	localparam int CNT_W = 16;

	// Message identity
	localparam logic [2:0] MSG_PRIORITY = 3'h3;
	localparam logic [17:0] MSG_PGN = 18'h0FDD6;
	localparam logic [3:0] MSG_DLC = 4'h8;

	// Two-bit status codes
	localparam logic [1:0] CODE_OFF = 2'h0;
	localparam logic [1:0] CODE_ON = 2'h1;
	localparam logic [1:0] CODE_ERR = 2'h2;
	localparam logic [1:0] CODE_NA = 2'h3;

	// Position codes
	localparam logic [POS_W-1:0] POS_FULL_SCALE = 10'h3E8;
	localparam logic [POS_W-1:0] POS_FAULT = 10'h3FE;
	localparam logic [POS_W-1:0] POS_ABSENT = 10'h3FF;
	localparam logic [3:0] BYTE4_FILL = 4'hF;

	// Field offsets in the 64-bit data field, byte n at [8n+7:8n]
	localparam int X_NEUT_LSB = 0;
	localparam int X_NEG_LSB = 2;
	localparam int X_PSIDE_LSB = 4;
	localparam int X_POS_LSB = 6;
	localparam int Y_NEUT_LSB = 16;
	localparam int Y_NEG_LSB = 18;
	localparam int Y_PSIDE_LSB = 20;
	localparam int Y_POS_LSB = 22;
	localparam int FILL_LSB = 32;
	localparam int Y_DET_LSB = 36;
	localparam int X_DET_LSB = 38;
	localparam int BTN_BYTE_LSB = 40;

	// Register map and reset values
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] REG_SRC_ADDR = 8'h04;
	localparam logic [ADR_W-1:0] REG_BTN_FIT = 8'h08;
	localparam logic [ADR_W-1:0] REG_STATUS = 8'h0C;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_XP_BIT = 1;
	localparam int CTRL_YP_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h6;
	localparam logic [SA_W-1:0] SRC_ADDR_RST = 8'h00;
	localparam logic [BTN_N-1:0] BTN_FIT_RST = 12'hFFF;

	typedef enum logic [1:0] {S_IDLE, S_PACK, S_SEND} jsfp_state_t;
endpackage

// file: jsfp_cfg_if.sv
// Configuration and status carried between the register slave and the packer core.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface jsfp_cfg_if;
	import jsfp_pkg::*;
	logic enable;
	logic x_present;
	logic y_present;
	logic [SA_W-1:0] src_addr;
	logic [BTN_N-1:0] btn_fitted;
	logic busy;
	logic [CNT_W-1:0] frame_count;
	modport regs (output enable, x_present, y_present, src_addr, btn_fitted, input busy, frame_count);
	modport core (input enable, x_present, y_present, src_addr, btn_fitted, output busy, frame_count);
endinterface

// file: jsfp_axis_enc.sv
// Encodes one axis snapshot into its position and three side status fields.
// Assumes a signed travel input, negative meaning back, left, counterclockwise or down.
`timescale 1ns/1ps
module jsfp_axis_enc (
	input logic signed [jsfp_pkg::AXIS_IN_W-1:0] travel_i,
	input logic fault_i,
	input logic present_i,
	output logic [jsfp_pkg::POS_W-1:0] pos_o,
	output logic [1:0] neut_o,
	output logic [1:0] neg_o,
	output logic [1:0] pside_o
);
	import jsfp_pkg::*;

	logic is_neg;
	logic [AXIS_IN_W-1:0] mag;
	logic [AXIS_IN_W-1:0] full_scale;
	logic [POS_W-1:0] clamped;
	logic moved;

	assign is_neg = travel_i[AXIS_IN_W-1];
	assign mag = is_neg ? AXIS_IN_W'(-travel_i) : AXIS_IN_W'(travel_i);
	assign moved = (mag != '0);
	assign full_scale = {1'b0, POS_FULL_SCALE};
	assign clamped = (mag > full_scale) ? POS_FULL_SCALE : mag[POS_W-1:0];
	assign pos_o = !present_i ? POS_ABSENT : (fault_i ? POS_FAULT : clamped);
	assign neut_o = !present_i ? CODE_NA : (fault_i ? CODE_ERR : (moved ? CODE_OFF : CODE_ON));
	assign neg_o = !present_i ? CODE_NA : (fault_i ? CODE_ERR : ((moved && is_neg) ? CODE_ON : CODE_OFF));
	assign pside_o = !present_i ? CODE_NA : (fault_i ? CODE_ERR : ((moved && !is_neg) ? CODE_ON : CODE_OFF));
endmodule

// file: jsfp_wb_regs.sv
// Classic Wishbone slave holding the packer's control and status registers.
// Assumes a single-cycle master that holds its request until ack.
`timescale 1ns/1ps
module jsfp_wb_regs (
	input logic sys_clk_i,
	input logic srst_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [jsfp_pkg::ADR_W-1:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	jsfp_cfg_if.regs cfg
);
	import jsfp_pkg::*;

	logic [2:0] ctrl;
	logic [SA_W-1:0] src_addr;
	logic [BTN_N-1:0] btn_fitted;
	logic req;
	logic wr;
	logic hit_ctrl;
	logic hit_src;
	logic hit_btn;
	logic hit_stat;
	logic [31:0] next_rdata;

	// One access per request; ack drops the cycle after it rises
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Write lands at the edge where the master sees ack, not before
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign hit_ctrl = (wb_adr_i == REG_CTRL);
	assign hit_src = (wb_adr_i == REG_SRC_ADDR);
	assign hit_btn = (wb_adr_i == REG_BTN_FIT);
	assign hit_stat = (wb_adr_i == REG_STATUS);
	// Unmapped addresses read zero and ignore writes
	assign next_rdata = hit_ctrl ? {29'h0, ctrl} :
		hit_src ? {24'h0, src_addr} :
		hit_btn ? {20'h0, btn_fitted} :
		hit_stat ? {cfg.frame_count, 15'h0, cfg.busy} : 32'h0;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? next_rdata : 32'h0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctrl <= CTRL_RST;
			src_addr <= SRC_ADDR_RST;
			btn_fitted <= BTN_FIT_RST;
		end else begin
			if (wr && hit_ctrl && wb_sel_i[0])
				ctrl <= wb_dat_i[2:0];
			if (wr && hit_src && wb_sel_i[0])
				src_addr <= wb_dat_i[7:0];
			if (wr && hit_btn && wb_sel_i[0])
				btn_fitted[7:0] <= wb_dat_i[7:0];
			if (wr && hit_btn && wb_sel_i[1])
				btn_fitted[11:8] <= wb_dat_i[11:8];
		end
	end

	assign cfg.enable = ctrl[CTRL_EN_BIT];
	assign cfg.x_present = ctrl[CTRL_XP_BIT];
	assign cfg.y_present = ctrl[CTRL_YP_BIT];
	assign cfg.src_addr = src_addr;
	assign cfg.btn_fitted = btn_fitted;
endmodule

// file: jsfp_frame_packer.sv
// Joystick status frame packer: snapshots axis and button inputs every period
// and offers one 8-byte basic joystick data field with its identifier.
// Assumes a CAN controller that takes a frame on valid and ready both high.
//
// What this block does
// - X neutral, negative and positive status at byte 0 bits 1, 3, 5.
// - X position, 10 bits, LSB at byte 0 bit 7, MSB byte 1 bit 8.
// - Y neutral, back and forward status at byte 2 bits 1, 3, 5.
// - Y position, 10 bits, LSB at byte 2 bit 7, MSB byte 3 bit 8.
// - Y detent at byte 4 bit 5, X detent at byte 4 bit 7.
// - Buttons 4, 3, 2, 1 at byte 5 bits 1, 3, 5, 7.
// - Buttons 8, 7, 6, 5 at byte 6 bits 1, 3, 5, 7.
// - Buttons 12, 11, 10, 9 at byte 7 bits 1, 3, 5, 7.
// - Neutral status: 00 out, 01 in, 10 error, 11 unavailable.
// - Negative side status: 00 not, 01 on, 10 error, 11 unavailable.
// - Positive side status: 00 not, 01 on, 10 error, 11 unavailable.
// - Position is travel magnitude from neutral; zero means neutral.
// - End of linear zone reads 1000 counts.
// - Position measurement fault forces 1022 counts.
// - Axis not provided reads 1023 counts.
// - Back, left, ccw, down is negative; forward, right, cw, up positive.
// - Message sent every 20 ms.
// - Priority 3, group FDD6, fixed source address; identifier 0xCFDD6 plus address.
// - Data field always exactly eight bytes.
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module jsfp_frame_packer #(
	parameter int unsigned PERIOD_CYCLES = jsfp_pkg::FRAME_PERIOD_CYCLES
) (
	input logic sys_clk_i,
	input logic srst_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [jsfp_pkg::ADR_W-1:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input logic signed [jsfp_pkg::AXIS_IN_W-1:0] x_travel_i,
	input logic x_fault_i,
	input logic [1:0] x_detent_i,
	input logic signed [jsfp_pkg::AXIS_IN_W-1:0] y_travel_i,
	input logic y_fault_i,
	input logic [1:0] y_detent_i,
	input logic [jsfp_pkg::BTN_N-1:0] btn_pressed_i,
	input logic [jsfp_pkg::BTN_N-1:0] btn_fault_i,
	output logic frame_valid_o,
	input logic frame_ready_i,
	output logic [28:0] frame_id_o,
	output logic [3:0] frame_dlc_o,
	output logic [63:0] frame_data_o
);
	import jsfp_pkg::*;

	jsfp_cfg_if cfg ();
	jsfp_state_t state;
	logic [TIMER_W-1:0] timer;
	logic tick;
	logic [CNT_W-1:0] frame_count;

	// Snapshot
	logic signed [AXIS_IN_W-1:0] snap_x_travel;
	logic signed [AXIS_IN_W-1:0] snap_y_travel;
	logic snap_x_fault;
	logic snap_y_fault;
	logic snap_x_present;
	logic snap_y_present;
	logic [1:0] snap_x_det;
	logic [1:0] snap_y_det;
	logic [BTN_N-1:0] snap_pressed;
	logic [BTN_N-1:0] snap_bfault;
	logic [BTN_N-1:0] snap_fitted;
	logic [SA_W-1:0] snap_src;

	// Encoded fields
	logic [POS_W-1:0] x_pos;
	logic [POS_W-1:0] y_pos;
	logic [1:0] x_neut;
	logic [1:0] x_neg;
	logic [1:0] x_pside;
	logic [1:0] y_neut;
	logic [1:0] y_neg;
	logic [1:0] y_pside;
	logic [1:0] x_det;
	logic [1:0] y_det;
	logic [63:0] next_data;
	logic [28:0] next_id;
	logic take;

	jsfp_wb_regs u_regs (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.cfg(cfg.regs)
	);

	jsfp_axis_enc u_x_enc (
		.travel_i(snap_x_travel),
		.fault_i(snap_x_fault),
		.present_i(snap_x_present),
		.pos_o(x_pos),
		.neut_o(x_neut),
		.neg_o(x_neg),
		.pside_o(x_pside)
	);

	jsfp_axis_enc u_y_enc (
		.travel_i(snap_y_travel),
		.fault_i(snap_y_fault),
		.present_i(snap_y_present),
		.pos_o(y_pos),
		.neut_o(y_neut),
		.neg_o(y_neg),
		.pside_o(y_pside)
	);

	assign tick = cfg.enable && (timer == TIMER_W'(PERIOD_CYCLES - 1));

	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !cfg.enable || tick)
			timer <= '0;
		else
			timer <= timer + 1'b1;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			snap_x_travel <= '0;
			snap_y_travel <= '0;
			snap_x_fault <= 1'b0;
			snap_y_fault <= 1'b0;
			snap_x_present <= 1'b0;
			snap_y_present <= 1'b0;
			snap_x_det <= CODE_NA;
			snap_y_det <= CODE_NA;
			snap_pressed <= '0;
			snap_bfault <= '0;
			snap_fitted <= '0;
			snap_src <= '0;
		end else if (state == S_IDLE && tick) begin
			snap_x_travel <= x_travel_i;
			snap_y_travel <= y_travel_i;
			snap_x_fault <= x_fault_i;
			snap_y_fault <= y_fault_i;
			snap_x_present <= cfg.x_present;
			snap_y_present <= cfg.y_present;
			snap_x_det <= x_detent_i;
			snap_y_det <= y_detent_i;
			snap_pressed <= btn_pressed_i;
			snap_bfault <= btn_fault_i;
			snap_fitted <= cfg.btn_fitted;
			snap_src <= cfg.src_addr;
		end
	end

	// Detent status of an absent axis is unavailable
	assign x_det = snap_x_present ? snap_x_det : CODE_NA;
	assign y_det = snap_y_present ? snap_y_det : CODE_NA;

	assign next_data[X_NEUT_LSB +: 2] = x_neut;
	assign next_data[X_NEG_LSB +: 2] = x_neg;
	assign next_data[X_PSIDE_LSB +: 2] = x_pside;
	assign next_data[X_POS_LSB +: POS_W] = x_pos;
	assign next_data[Y_NEUT_LSB +: 2] = y_neut;
	assign next_data[Y_NEG_LSB +: 2] = y_neg;
	assign next_data[Y_PSIDE_LSB +: 2] = y_pside;
	assign next_data[Y_POS_LSB +: POS_W] = y_pos;
	// unused low nibble of byte 4
	assign next_data[FILL_LSB +: 4] = BYTE4_FILL;
	assign next_data[Y_DET_LSB +: 2] = y_det;
	assign next_data[X_DET_LSB +: 2] = x_det;

	// buttons, highest number of each group in bit 1
	for (genvar i = 0; i < BTN_N; i++) begin : g_btn
		assign next_data[BTN_BYTE_LSB + 8 * (i / 4) + 6 - 2 * (i % 4) +: 2] =
			!snap_fitted[i] ? CODE_NA : (snap_bfault[i] ? CODE_ERR : (snap_pressed[i] ? CODE_ON : CODE_OFF));
	end

	// identifier from priority, group and fixed source address
	assign next_id = {MSG_PRIORITY, MSG_PGN, snap_src};
	assign take = frame_valid_o && frame_ready_i;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE: begin
					if (tick)
						state <= S_PACK;
				end
				S_PACK: state <= S_SEND;
				S_SEND: begin
					if (frame_ready_i)
						state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Frame held stable until the controller takes it; a tick during a stall is dropped
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			frame_valid_o <= 1'b0;
			frame_id_o <= '0;
			frame_dlc_o <= '0;
			frame_data_o <= '0;
		end else if (state == S_PACK) begin
			frame_valid_o <= 1'b1;
			frame_id_o <= next_id;
			frame_dlc_o <= MSG_DLC;
			frame_data_o <= next_data;
		end else if (take) begin
			frame_valid_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			frame_count <= '0;
		else if (take)
			frame_count <= frame_count + 1'b1;
	end

	assign cfg.busy = (state != S_IDLE);
	assign cfg.frame_count = frame_count;

	// Checks
	logic [31:0] gap;
	logic run_ok;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i || tick)
			gap <= '0;
		else
			gap <= gap + 1'b1;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !cfg.enable)
			run_ok <= 1'b0;
		else if (tick)
			run_ok <= 1'b1;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	chk_tick_period: assert property (tick && run_ok |-> gap == 32'(PERIOD_CYCLES - 1))
		else $error("frame period wrong");
	chk_dlc_eight: assert property (frame_valid_o |-> frame_dlc_o == 4'h8)
		else $error("data length not eight");
	chk_id_fixed: assert property (frame_valid_o |-> frame_id_o[28:8] == 21'h0CFDD6)
		else $error("identifier wrong");
	chk_fill_ones: assert property (frame_valid_o |-> frame_data_o[35:32] == 4'hF)
		else $error("byte 4 fill wrong");
	chk_fault_pos: assert property (state == S_PACK && snap_x_present && snap_x_fault
		|=> frame_data_o[15:6] == 10'h3FE && frame_data_o[1:0] == 2'h2)
		else $error("fault code missing");
	chk_absent_pos: assert property (state == S_PACK && !snap_y_present
		|=> frame_data_o[31:22] == 10'h3FF && frame_data_o[17:16] == 2'h3)
		else $error("absent code missing");
	chk_full_scale: assert property (state == S_PACK && snap_x_present && !snap_x_fault
		&& snap_x_travel > 11'sh3E8 |=> frame_data_o[15:6] == 10'h3E8)
		else $error("full scale wrong");
	chk_neutral_zero: assert property (frame_valid_o && frame_data_o[1:0] == 2'h1
		|-> frame_data_o[15:6] == 10'h0 && frame_data_o[5:2] == 4'h0)
		else $error("neutral with travel");
	chk_neg_side: assert property (state == S_PACK && snap_x_present && !snap_x_fault
		&& snap_x_travel < 0 |=> frame_data_o[3:2] == 2'h1 && frame_data_o[5:4] == 2'h0)
		else $error("negative side wrong");
	chk_button_one: assert property (state == S_PACK && snap_fitted[0] && !snap_bfault[0]
		&& snap_pressed[0] |=> frame_data_o[47:46] == 2'h1)
		else $error("button 1 misplaced");
	chk_button_twelve: assert property (state == S_PACK && !snap_fitted[11]
		|=> frame_data_o[57:56] == 2'h3)
		else $error("button 12 misplaced");
	chk_hold_stall: assert property (frame_valid_o && !frame_ready_i
		|=> frame_valid_o && $stable(frame_data_o) && $stable(frame_id_o))
		else $error("frame changed while held");
	chk_snap_inputs: assert property (state == S_IDLE && tick
		|=> snap_x_travel == $past(x_travel_i) && snap_pressed == $past(btn_pressed_i))
		else $error("snapshot not taken");

	cov_frame_sent: cover property (take);
	cov_stalled: cover property (frame_valid_o && !frame_ready_i ##1 take);
	cov_fault_frame: cover property (state == S_PACK && snap_x_fault);
	cov_tick_dropped: cover property (tick && state == S_SEND);
endmodule

// file: jsfp_can_model.sv
// Behavioural CAN controller standing at the packer's frame link.
// Assumes the packer holds valid, id, dlc and data steady until taken.
`timescale 1ns/1ps
module jsfp_can_model (
	input logic sys_clk_i,
	input logic srst_i,
	input logic frame_valid_i,
	input logic [28:0] frame_id_i,
	input logic [3:0] frame_dlc_i,
	input logic [63:0] frame_data_i,
	output logic frame_ready_o,
	output logic [28:0] cap_id_o,
	output logic [3:0] cap_dlc_o,
	output logic [63:0] cap_data_o,
	output logic [15:0] n_got_o
);
	logic [15:0] lfsr;

	// Stalls about one cycle in four, so a frame may wait before it is taken
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			lfsr <= 16'hACE1;
			frame_ready_o <= 1'b0;
			n_got_o <= 16'h0;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			frame_ready_o <= (lfsr[1:0] != 2'h0);
			if (frame_valid_i && frame_ready_o) begin
				cap_id_o <= frame_id_i;
				cap_dlc_o <= frame_dlc_i;
				cap_data_o <= frame_data_i;
				n_got_o <= n_got_o + 16'h1;
			end
		end
	end
endmodule

// file: joystick_status_frame_packer_tb.sv
// Self-checking bench for the frame packer: Wishbone setup, random and corner
// axis and button stimulus, frames taken by the CAN controller model.
`timescale 1ns/1ps
module joystick_status_frame_packer_tb;
	import jsfp_pkg::*;
	localparam int P = 50;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [3:0] sel = 4'hF;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic signed [10:0] x_t = 11'h000;
	logic signed [10:0] y_t = 11'h000;
	logic x_f = 1'b0;
	logic y_f = 1'b0;
	logic [1:0] x_d = 2'h0;
	logic [1:0] y_d = 2'h0;
	logic [11:0] b_p = 12'h000;
	logic [11:0] b_f = 12'h000;
	logic valid, ready;
	logic [28:0] f_id, cap_id;
	logic [3:0] f_dlc, cap_dlc;
	logic [63:0] f_data, cap_data, exp_q;
	logic [15:0] n_got, n_seen;
	logic [31:0] seed = 32'h11;
	logic [31:0] q;
	logic [2:0] ctrl = 3'h6;
	logic [11:0] fit = 12'hFFF;
	logic [7:0] sa;
	int err_count = 0;
	int n_tests = 0;
	int cyc_n = 0;
	int t_prev = 0;
	int cx[8] = '{0, 1000, 1001, -1000, -1024, 1023, -1, 1};

	jsfp_frame_packer #(.PERIOD_CYCLES(P)) i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .x_travel_i(x_t), .x_fault_i(x_f), .x_detent_i(x_d),
		.y_travel_i(y_t), .y_fault_i(y_f), .y_detent_i(y_d), .btn_pressed_i(b_p), .btn_fault_i(b_f),
		.frame_valid_o(valid), .frame_ready_i(ready), .frame_id_o(f_id), .frame_dlc_o(f_dlc),
		.frame_data_o(f_data));
	jsfp_can_model i_can (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .frame_valid_i(valid), .frame_id_i(f_id),
		.frame_dlc_i(f_dlc), .frame_data_i(f_data), .frame_ready_o(ready), .cap_id_o(cap_id),
		.cap_dlc_o(cap_dlc), .cap_data_o(cap_data), .n_got_o(n_got));

	initial begin
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) cyc_n <= cyc_n + 1;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] enc(logic signed [10:0] t, logic f, logic p);
		int a;
		a = t;
		if (!p) return 16'hFFFF;
		if (f) return {10'h3FE, 6'h2A};
		if (a < 0) a = -a;
		if (a > 1000) a = 1000;
		return {a[9:0], 1'b0, t > 0, 1'b0, t < 0, 1'b0, t == 0};
	endfunction

	function automatic logic [63:0] calc();
		logic [63:0] d;
		d = 64'h0;
		d[15:0] = enc(x_t, x_f, ctrl[1]);
		d[31:16] = enc(y_t, y_f, ctrl[2]);
		d[35:32] = 4'hF;
		d[37:36] = ctrl[2] ? y_d : 2'h3;
		d[39:38] = ctrl[1] ? x_d : 2'h3;
		for (int k = 0; k < 12; k++) begin
			d[40 + 8 * (k / 4) + 2 * (3 - k % 4) +: 2] = !fit[k] ? 2'h3 : b_f[k] ? 2'h2 : b_p[k] ? 2'h1 : 2'h0;
		end
		return d;
	endfunction

	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chk64(input string nm, input logic [63:0] e, input logic [63:0] s);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge sys_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= sel;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// Only the watchdog ends a wait for ack
		do begin
			@(posedge sys_clk_i);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic drive(input bit corner, input int i);
		logic [31:0] r;
		r = rnd();
		x_t <= corner ? 11'(cx[i]) : r[10:0];
		y_t <= corner ? 11'(cx[7 - i]) : r[21:11];
		x_d <= r[23:22];
		y_d <= r[25:24];
		x_f <= !corner && r[28:26] == 3'h0;
		y_f <= !corner && r[31:29] == 3'h0;
		r = rnd();
		b_p <= r[11:0];
		b_f <= r[23:12] & r[31:20];
	endtask

	// Inputs change while a frame is pending; it must still show the old snapshot
	task automatic step(input logic [2:0] c, input bit corner, input int i, input bit per);
		do begin
			@(posedge sys_clk_i);
		end while (valid !== 1'b1);
		if (per) chk32("period", P, cyc_n - t_prev);
		t_prev = cyc_n;
		drive(corner, i);
		do begin
			@(posedge sys_clk_i);
		end while (n_got === n_seen);
		n_seen = n_got;
		chk64("data", exp_q, cap_data);
		chk32("id", {4'h0, 20'hCFDD6, sa}, {3'h0, cap_id});
		chk32("dlc", 32'h8, {28'h0, cap_dlc});
		fit = 12'(rnd());
		wb(1'b1, 8'h08, {20'h0, fit}, q);
		if (c !== ctrl) begin
			ctrl = c;
			wb(1'b1, 8'h00, {29'h0, c}, q);
		end
		exp_q = calc();
	endtask

	task automatic stop_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_count++;
		stop_test();
	end

	initial begin
		n_seen = 16'h0;
		repeat (5) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		wb(1'b0, 8'h00, 32'h0, q);
		chk32("ctrl_rst", 32'h6, q);
		wb(1'b0, 8'h04, 32'h0, q);
		chk32("sa_rst", 32'h0, q);
		wb(1'b0, 8'h08, 32'h0, q);
		chk32("fit_rst", 32'hFFF, q);
		// Unmapped place: write ignored, reads zero
		wb(1'b1, 8'h10, 32'hFFFFFFFF, q);
		wb(1'b0, 8'h10, 32'h0, q);
		chk32("unmapped", 32'h0, q);
		// Lane 1 alone reaches the top nibble of the fitted mask
		sel = 4'h2;
		wb(1'b1, 8'h08, 32'h0, q);
		sel = 4'hF;
		wb(1'b0, 8'h08, 32'h0, q);
		chk32("fit_lane", 32'hFF, q);
		wb(1'b1, 8'h08, 32'hFFF, q);
		sa = 8'(rnd());
		wb(1'b1, 8'h04, {24'h0, sa}, q);
		drive(1'b1, 0);
		@(posedge sys_clk_i);
		ctrl = 3'h7;
		exp_q = calc();
		wb(1'b1, 8'h00, 32'h7, q);
		for (int i = 0; i < 30; i++) begin
			step((i + 1) < 10 ? 3'h7 : (i + 1) < 20 ? 3'h3 : 3'h5, (i + 1) < 8, i + 1, i % 10 != 0);
		end
		// Disabled: no further tick, no frame, busy stays low
		wb(1'b1, 8'h00, 32'h6, q);
		repeat (2 * P) @(posedge sys_clk_i);
		// Count is read-only and must equal the frames taken
		wb(1'b1, 8'h0C, 32'hFFFFFFFF, q);
		wb(1'b0, 8'h0C, 32'h0, q);
		chk32("count", {16'h0, n_got}, {16'h0, q[31:16]});
		chk32("busy", 32'h0, {16'h0, q[15:0]});
		chk32("n_got", 32'h1E, {16'h0, n_got});
		stop_test();
	end
endmodule
